/* File: tb/scp_prog_port_asserts.sv */
// Purpose: Port-level checks for the synthesizer programming port
// Assumes: Pins held for five block clocks have passed the synchroniser
// Notes: Antecedents span several cycles to absorb the synchroniser delay
`timescale 1ns/1ns
module scp_prog_port_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic serial_mode,
	input wire logic bus_mode,
	input wire logic option_enable_n,
	input wire scp_pkg::scp_ref_t ref_count,
	input wire scp_pkg::scp_main_t main_count,
	input wire scp_pkg::scp_opt_t option_active,
	input wire logic data_out,
	input wire logic main_monitor,
	input wire logic ref_monitor,
	input wire logic pump_up_n,
	input wire logic pump_down_n,
	input wire logic lock_filter,
	input wire logic lock_indicator_out,
	input wire logic lock_indicator_oe,
	input wire logic charge_pump_out,
	input wire logic charge_pump_oe,
	input wire scp_pkg::scp_mode_t port_mode
);
	import scp_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence direct_held;
		bus_mode [*6];
	endsequence
	sequence up_held;
		(!pump_up_n && pump_down_n) [*2];
	endsequence
	sequence down_held;
		(pump_up_n && !pump_down_n) [*2];
	endsequence
	mode_direct_a: assert property (bus_mode [*5] |=> port_mode == SCP_MODE_DIR)
		else $error("port mode not direct");
	mode_serial_a: assert property ((!bus_mode && serial_mode) [*5] |=>
		port_mode == SCP_MODE_SER)
		else $error("port mode not serial");
	direct_zero_a: assert property (direct_held |=>
		ref_count[5:4] == 2'b00 && main_count[8:7] == 2'b00)
		else $error("direct mode upper bits not zero");
	opt_gate_a: assert property ((option_enable_n || bus_mode) [*5] |=>
		option_active == SCP_OPT_RST)
		else $error("options active while disabled");
	dout_off_a: assert property ((!option_active[SCP_OPT_DOUT_EN]) [*3] |-> !data_out)
		else $error("data out driven while off");
	main_mon_a: assert property (option_active[SCP_OPT_MAIN_MON_OFF] [*3] |->
		$stable(main_monitor))
		else $error("main monitor toggles while off");
	ref_mon_a: assert property (option_active[SCP_OPT_REF_MON_OFF] [*3] |->
		$stable(ref_monitor))
		else $error("reference monitor toggles while off");
	filt_up_a: assert property (!pump_up_n |-> ##[0:1] lock_filter)
		else $error("filter low while pumping");
	lock_drive_a: assert property (lock_filter [*2] |->
		lock_indicator_oe && !lock_indicator_out)
		else $error("lock indicator not driven low");
	lock_float_a: assert property ((!lock_filter) [*2] |-> !lock_indicator_oe)
		else $error("lock indicator driven while locked");
	pump_src_a: assert property (up_held |-> charge_pump_oe && charge_pump_out)
		else $error("charge pump not sourcing");
	pump_snk_a: assert property (down_held |-> charge_pump_oe && !charge_pump_out)
		else $error("charge pump not sinking");
endmodule

bind scp_prog_port scp_prog_port_asserts u_chk (.clk(clk), .reset(reset),
	.serial_mode(serial_mode), .bus_mode(bus_mode), .option_enable_n(option_enable_n),
	.ref_count(ref_count), .main_count(main_count), .option_active(option_active),
	.data_out(data_out), .main_monitor(main_monitor), .ref_monitor(ref_monitor),
	.pump_up_n(pump_up_n), .pump_down_n(pump_down_n), .lock_filter(lock_filter),
	.lock_indicator_out(lock_indicator_out), .lock_indicator_oe(lock_indicator_oe),
	.charge_pump_out(charge_pump_out), .charge_pump_oe(charge_pump_oe),
	.port_mode(port_mode));

/* File: tb/scp_ser_host.sv */
// Purpose: Serial controller that loads the programming port
// Assumes: Shift clock period 800 ns, idle low between frames
// Notes: Data returns to the pull-down level when not shifting
`timescale 1ns/1ns
module scp_ser_host (
	output logic shift_clock,
	output logic shift_data,
	output logic serial_load_strobe,
	output logic option_strobe
);
	import scp_pkg::*;
	initial begin
		shift_clock = 1'b0;
		shift_data = 1'b0;
		serial_load_strobe = 1'b0;
		option_strobe = 1'b0;
	end
	task automatic bit_out(input logic b);
		shift_data = b;
		#400 shift_clock = 1'b1;
		#400 shift_clock = 1'b0;
	endtask
	// Leaves the load strobe alone so a bench can shift while it is high
	task automatic shift_word(input scp_word_t w);
		for (int i = SCP_STAGE_W - 1; i >= 0; i--) begin
			bit_out(w[i]);
		end
		shift_data = 1'b0;
	endtask
	task automatic send_word(input scp_word_t w);
		serial_load_strobe = 1'b0;
		#400;
		shift_word(w);
		#400 serial_load_strobe = 1'b1;
		#400;
	endtask
	task automatic send_opt(input scp_opt_t v);
		option_strobe = 1'b1;
		serial_load_strobe = 1'b0;
		#400;
		for (int i = SCP_OPT_W - 1; i >= 0; i--) begin
			bit_out(v[i]);
		end
		shift_data = 1'b0;
		#400 option_strobe = 1'b0;
		#400;
	endtask
endmodule

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the synthesizer programming port
// Assumes: Host model drives the serial pins, the bench all others
// Notes: Fixed settle waits, since the port gives no completion signal
`timescale 1ns/1ns
module tb;
	import scp_pkg::*;
	typedef struct {
		scp_byte_t upper;
		scp_byte_t main;
		scp_byte_t swal;
		scp_word_t exp;
	} scp_row_t;
	logic clk, reset, shift_clock, shift_data, serial_load_strobe, host_opt;
	logic serial_copy_select, parallel_copy_select, serial_mode, bus_mode, option_enable_n;
	logic modulus_select, prescaler_raw, main_div, ref_div, prescaler_bypass, data_out;
	logic main_monitor, ref_monitor, pump_up_n, pump_down_n, lock_filter;
	logic lock_indicator_out, lock_indicator_oe, charge_pump_out, charge_pump_oe;
	logic [4:0] stb;
	scp_byte_t bus_data;
	scp_refpin_t ref_pins;
	scp_ref_t ref_count;
	scp_main_t main_count;
	scp_swal_t swallow_count;
	scp_opt_t option_active;
	scp_mode_t port_mode;
	int bad_count, checks_done;
	// Exp packs bypass, reference, main and swallow
	scp_row_t rows[3] = '{
		'{8'h0f, 8'hff, 8'hff, {1'b1, 6'h3f, 9'h1ff, 4'hf}},
		'{8'h09, 8'h2a, 8'h5c, {1'b0, 6'h25, 9'h0aa, 4'hc}},
		'{8'h06, 8'h81, 8'ha3, {1'b1, 6'h1a, 9'h101, 4'h3}}};
	scp_ser_host host (.shift_clock(shift_clock), .shift_data(shift_data),
		.serial_load_strobe(serial_load_strobe), .option_strobe(host_opt));
	scp_prog_port uut (.clk(clk), .reset(reset), .bus_data(bus_data), .ref_pins(ref_pins),
		.shift_clock(shift_clock), .shift_data(shift_data),
		.serial_load_strobe(serial_load_strobe), .option_strobe(stb[3] | host_opt),
		.main_field_strobe(stb[1]), .upper_field_strobe(stb[0]),
		.swallow_field_strobe(stb[2]), .hop_strobe(stb[4]),
		.serial_copy_select(serial_copy_select), .parallel_copy_select(parallel_copy_select),
		.serial_mode(serial_mode), .bus_mode(bus_mode), .option_enable_n(option_enable_n),
		.modulus_select(modulus_select), .prescaler_raw(prescaler_raw),
		.main_div(main_div), .ref_div(ref_div), .ref_count(ref_count),
		.main_count(main_count), .swallow_count(swallow_count),
		.prescaler_bypass(prescaler_bypass), .option_active(option_active),
		.data_out(data_out), .main_monitor(main_monitor), .ref_monitor(ref_monitor),
		.pump_up_n(pump_up_n), .pump_down_n(pump_down_n), .lock_filter(lock_filter),
		.lock_indicator_out(lock_indicator_out), .lock_indicator_oe(lock_indicator_oe),
		.charge_pump_out(charge_pump_out), .charge_pump_oe(charge_pump_oe),
		.port_mode(port_mode));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task automatic chk(input scp_word_t seen, input scp_word_t exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic scp_word_t counts();
		return {prescaler_bypass, ref_count, main_count, swallow_count};
	endfunction
	function automatic scp_word_t decode(input scp_word_t w);
		return {w[15], w[19:18], w[7:4], w[17:16], w[14:8], w[3:0]};
	endfunction
	// Strobe index: 0 upper, 1 main, 2 swallow, 3 option, 4 hop
	task automatic pulse(input int k, input scp_byte_t d);
		bus_data = d;
		stb[k] = 1'b1;
		step(4);
		stb[k] = 1'b0;
		step(4);
	endtask
	task automatic print_verdict();
		if (bad_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{reset, stb, bus_data, ref_pins} = {1'b1, 5'h00, 8'h00, 4'h0};
		{serial_copy_select, parallel_copy_select, serial_mode, bus_mode} = 4'h0;
		{option_enable_n, modulus_select, prescaler_raw, main_div, ref_div} = 5'h10;
		bad_count = 0;
		checks_done = 0;
		step(2);
		reset = 1'b0;
		chk(counts(), SCP_WORD_RST);
		parallel_copy_select = 1'b1;
		foreach (rows[i]) begin
			pulse(0, rows[i].upper);
			pulse(1, rows[i].main);
			pulse(2, rows[i].swal);
			chk(counts(), rows[i].exp);
		end
		chk(20'(port_mode), 20'(SCP_MODE_PAR));
		parallel_copy_select = 1'b0;
		step(6);
		chk(counts(), SCP_WORD_RST);
		pulse(4, 8'h00);
		chk(counts(), rows[2].exp);
		pulse(1, rows[0].main);
		chk(counts(), rows[2].exp);
		option_enable_n = 1'b0;
		pulse(3, 8'h80);
		modulus_select = 1'b1;
		step(6);
		chk(20'(data_out), 20'h1);
		pulse(3, 8'hc0);
		chk(20'(option_active), 20'hc0);
		chk(20'(data_out), 20'h0);
		prescaler_raw = 1'b1;
		step(6);
		chk(20'(data_out), 20'h1);
		pulse(3, 8'h30);
		{main_div, ref_div} = 2'b11;
		step(4);
		chk(20'({main_monitor, ref_monitor}), 20'h0);
		{main_div, ref_div} = 2'b00;
		step(8);
		option_enable_n = 1'b1;
		step(6);
		chk(20'(option_active), 20'h0);
		{main_div, ref_div} = 2'b11;
		step(4);
		chk(20'({main_monitor, ref_monitor}), 20'h3);
		{main_div, ref_div} = 2'b00;
		step(8);
		serial_mode = 1'b1;
		step(6);
		chk(20'(port_mode), 20'(SCP_MODE_SER));
		chk(counts(), rows[2].exp);
		host.send_word(20'hb5a3c);
		step(6);
		chk(counts(), decode(20'hb5a3c));
		serial_copy_select = 1'b1;
		host.shift_word(20'h4c3a5);
		step(6);
		chk(counts(), decode(20'hb5a3c));
		option_enable_n = 1'b0;
		host.send_opt(8'h85);
		step(6);
		chk(20'(option_active), 20'h85);
		reset = 1'b1;
		step(2);
		chk({counts()}, SCP_WORD_RST);
		chk(20'(option_active), 20'h0);
		reset = 1'b0;
		{bus_mode, bus_data, ref_pins, parallel_copy_select} = {1'b1, 8'hff, 4'ha, 1'b1};
		step(8);
		chk(20'(port_mode), 20'(SCP_MODE_DIR));
		chk(counts(), {1'b1, 6'h0a, 9'h07f, 4'h9});
		chk(20'(option_active), 20'h0);
		{bus_mode, serial_mode, option_enable_n} = 3'b001;
		ref_div = 1'b1;
		step(2);
		ref_div = 1'b0;
		step(6);
		chk(20'({pump_up_n, pump_down_n, charge_pump_oe, charge_pump_out}), 20'h7);
		chk(20'({lock_filter, lock_indicator_oe, lock_indicator_out}), 20'h6);
		main_div = 1'b1;
		step(2);
		main_div = 1'b0;
		step(8);
		chk(20'({pump_up_n, pump_down_n, charge_pump_oe, lock_filter}), 20'hc);
		chk(20'(lock_indicator_oe), 20'h0);
		main_div = 1'b1;
		step(2);
		main_div = 1'b0;
		step(6);
		chk(20'({pump_up_n, pump_down_n, charge_pump_oe, charge_pump_out}), 20'ha);
		ref_div = 1'b1;
		step(2);
		ref_div = 1'b0;
		step(8);
		print_verdict();
	end
endmodule

/* File: verilog/scp_phase_det.sv */
// Purpose: Edge-based phase-frequency detector
// Assumes: Divider edges arrive as single-cycle pulses
// Notes: Both pumps clear together once the second edge arrives
`timescale 1ns/1ns
module scp_phase_det (
	input wire logic clk,
	input wire logic reset,
	input wire logic ref_edge,
	input wire logic main_edge,
	output logic pump_up,
	output logic pump_down
);
	logic next_up;
	logic next_down;

	always_comb begin
		next_up = pump_up | ref_edge;
		next_down = pump_down | main_edge;
		// Coincident edges cancel instead of leaving a pulse behind
		if (next_up && next_down) begin
			next_up = 1'b0;
			next_down = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pump_up <= 1'b0;
			pump_down <= 1'b0;
		end else begin
			pump_up <= next_up;
			pump_down <= next_down;
		end
	end
endmodule

/* File: verilog/scp_pin_sync.sv */
// Purpose: Two-flop synchroniser and edge finder for every pin
// Assumes: Pins are slow against the block clock
// Notes: Only the second flop and its one-cycle delayed copy feed the edge logic
`timescale 1ns/1ns
module scp_pin_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic [scp_pkg::SCP_PINS-1:0] pins,
	scp_sync_if.src sync
);
	import scp_pkg::*;

	logic [SCP_PINS-1:0] meta;
	logic [SCP_PINS-1:0] stable;
	logic [SCP_PINS-1:0] prev;

	genvar i;
	generate
		for (i = 0; i < SCP_PINS; i++) begin : g_pin
			always_ff @(posedge clk) begin
				if (reset) begin
					meta[i] <= 1'b0;
					stable[i] <= 1'b0;
					prev[i] <= 1'b0;
				end else begin
					meta[i] <= pins[i];
					stable[i] <= meta[i];
					prev[i] <= stable[i];
				end
			end
			assign sync.level[i] = stable[i];
			assign sync.rise[i] = stable[i] & ~prev[i];
			assign sync.fall[i] = ~stable[i] & prev[i];
		end
	endgenerate
endmodule

/* File: verilog/scp_pkg.sv */
// Purpose: Shared constants and types for the synthesizer programming port
// Assumes: All pins arrive asynchronously and are synchronised before use
// Notes: Staging word, MSB first: ref high, main high, prescaler, main low, ref low, swallow
package scp_pkg;
	localparam int SCP_STAGE_W = 20;
	localparam int SCP_OPT_W = 8;
	localparam int SCP_BUS_W = 8;
	localparam int SCP_REFPIN_W = 4;
	localparam int SCP_REF_W = 6;
	localparam int SCP_MAIN_W = 9;
	localparam int SCP_SWAL_W = 4;

	typedef logic [SCP_STAGE_W-1:0] scp_word_t;
	typedef logic [SCP_OPT_W-1:0] scp_opt_t;
	typedef logic [SCP_BUS_W-1:0] scp_byte_t;
	typedef logic [SCP_REFPIN_W-1:0] scp_refpin_t;
	typedef logic [SCP_REF_W-1:0] scp_ref_t;
	typedef logic [SCP_MAIN_W-1:0] scp_main_t;
	typedef logic [SCP_SWAL_W-1:0] scp_swal_t;

	typedef enum logic [1:0] {
		SCP_MODE_PAR = 2'b00,
		SCP_MODE_SER = 2'b01,
		SCP_MODE_DIR = 2'b10
	} scp_mode_t;

	// Staging word field positions
	localparam int SCP_F_REF_HI = 18;
	localparam int SCP_F_MAIN_HI = 16;
	localparam int SCP_F_PRE = 15;
	localparam int SCP_F_MAIN_LO = 8;
	localparam int SCP_F_REF_LO = 4;
	localparam int SCP_F_SWAL = 0;
	localparam int SCP_F_UPPER = 16;

	// Option register bit positions
	localparam int SCP_OPT_DOUT_EN = 7;
	localparam int SCP_OPT_DOUT_RAW = 6;
	localparam int SCP_OPT_MAIN_MON_OFF = 5;
	localparam int SCP_OPT_REF_MON_OFF = 4;

	localparam scp_word_t SCP_WORD_RST = 20'h00000;
	localparam scp_opt_t SCP_OPT_RST = 8'h00;

	// Indices into the synchronised pin vector
	localparam int SCP_I_BUS = 0;
	localparam int SCP_I_REFPIN = 8;
	localparam int SCP_I_SCLK = 12;
	localparam int SCP_I_SDATA = 13;
	localparam int SCP_I_SLOAD = 14;
	localparam int SCP_I_OPT = 15;
	localparam int SCP_I_MAINWR = 16;
	localparam int SCP_I_UPPERWR = 17;
	localparam int SCP_I_SWALWR = 18;
	localparam int SCP_I_HOP = 19;
	localparam int SCP_I_SSEL = 20;
	localparam int SCP_I_PSEL = 21;
	localparam int SCP_I_SMODE = 22;
	localparam int SCP_I_BMODE = 23;
	localparam int SCP_I_ENH_N = 24;
	localparam int SCP_I_MODSEL = 25;
	localparam int SCP_I_PRESC = 26;
	localparam int SCP_I_MAINDIV = 27;
	localparam int SCP_I_REFDIV = 28;
	localparam int SCP_PINS = 29;
endpackage

/* File: verilog/scp_prog_port.sv */
// Purpose: Counter programming port, option control and lock outputs
// Assumes: Every pin is asynchronous; serial shift clock is far slower than clk
// Notes: Counter and prescaler datapaths live outside this block
`timescale 1ns/1ns

module scp_prog_port (
	input wire logic clk,
	input wire logic reset,
	input wire scp_pkg::scp_byte_t bus_data,
	input wire scp_pkg::scp_refpin_t ref_pins,
	input wire logic shift_clock,
	input wire logic shift_data,
	input wire logic serial_load_strobe,
	input wire logic option_strobe,
	input wire logic main_field_strobe,
	input wire logic upper_field_strobe,
	input wire logic swallow_field_strobe,
	input wire logic hop_strobe,
	input wire logic serial_copy_select,
	input wire logic parallel_copy_select,
	input wire logic serial_mode,
	input wire logic bus_mode,
	input wire logic option_enable_n,
	input wire logic modulus_select,
	input wire logic prescaler_raw,
	input wire logic main_div,
	input wire logic ref_div,
	output scp_pkg::scp_ref_t ref_count,
	output scp_pkg::scp_main_t main_count,
	output scp_pkg::scp_swal_t swallow_count,
	output logic prescaler_bypass,
	output scp_pkg::scp_opt_t option_active,
	output logic data_out,
	output logic main_monitor,
	output logic ref_monitor,
	output logic pump_up_n,
	output logic pump_down_n,
	output logic lock_filter,
	output logic lock_indicator_out,
	output logic lock_indicator_oe,
	output logic charge_pump_out,
	output logic charge_pump_oe,
	output scp_pkg::scp_mode_t port_mode
);
	import scp_pkg::*;

	scp_sync_if sync ();

	logic [SCP_PINS-1:0] pins;
	scp_word_t counter_staging_register;
	scp_word_t counter_shadow_copy;
	scp_opt_t option_control_register;
	scp_opt_t option_shift_buffer;
	scp_mode_t next_mode;
	scp_word_t selected;
	scp_ref_t next_ref;
	scp_main_t next_main;
	scp_swal_t next_swal;
	logic next_pre;
	scp_opt_t next_opt_active;
	logic pump_up;
	logic pump_down;
	logic ser_active;
	logic par_active;
	logic shift_take;
	scp_byte_t bus;
	logic next_dout;
	logic next_main_mon;
	logic next_ref_mon;
	logic next_pumping;

	assign pins[SCP_I_BUS +: SCP_BUS_W] = bus_data;
	assign pins[SCP_I_REFPIN +: SCP_REFPIN_W] = ref_pins;
	assign pins[SCP_I_SCLK] = shift_clock;
	assign pins[SCP_I_SDATA] = shift_data;
	assign pins[SCP_I_SLOAD] = serial_load_strobe;
	assign pins[SCP_I_OPT] = option_strobe;
	assign pins[SCP_I_MAINWR] = main_field_strobe;
	assign pins[SCP_I_UPPERWR] = upper_field_strobe;
	assign pins[SCP_I_SWALWR] = swallow_field_strobe;
	assign pins[SCP_I_HOP] = hop_strobe;
	assign pins[SCP_I_SSEL] = serial_copy_select;
	assign pins[SCP_I_PSEL] = parallel_copy_select;
	assign pins[SCP_I_SMODE] = serial_mode;
	assign pins[SCP_I_BMODE] = bus_mode;
	assign pins[SCP_I_ENH_N] = option_enable_n;
	assign pins[SCP_I_MODSEL] = modulus_select;
	assign pins[SCP_I_PRESC] = prescaler_raw;
	assign pins[SCP_I_MAINDIV] = main_div;
	assign pins[SCP_I_REFDIV] = ref_div;

	scp_pin_sync u_sync (
		.clk(clk),
		.reset(reset),
		.pins(pins),
		.sync(sync)
	);

	scp_phase_det u_pfd (
		.clk(clk),
		.reset(reset),
		.ref_edge(sync.rise[SCP_I_REFDIV]),
		.main_edge(sync.rise[SCP_I_MAINDIV]),
		.pump_up(pump_up),
		.pump_down(pump_down)
	);

	assign bus = sync.level[SCP_I_BUS +: SCP_BUS_W];

	// Mode pins decoded combinationally so a mode change acts at once
	always_comb begin
		if (sync.level[SCP_I_BMODE]) begin
			next_mode = SCP_MODE_DIR;
		end else if (sync.level[SCP_I_SMODE]) begin
			next_mode = SCP_MODE_SER;
		end else begin
			next_mode = SCP_MODE_PAR;
		end
	end

	assign ser_active = (next_mode == SCP_MODE_SER);
	assign par_active = (next_mode == SCP_MODE_PAR);
	// Shift clock edges only count while the load strobe is low
	assign shift_take = ser_active && sync.rise[SCP_I_SCLK] && !sync.level[SCP_I_SLOAD];

	always_ff @(posedge clk) begin
		if (reset) begin
			port_mode <= SCP_MODE_PAR;
		end else begin
			port_mode <= next_mode;
		end
	end

	// Staging register: serial shift or parallel field writes
	always_ff @(posedge clk) begin
		if (reset) begin
			counter_staging_register <= SCP_WORD_RST;
		end else if (shift_take && !sync.level[SCP_I_OPT]) begin
			counter_staging_register <= {counter_staging_register[SCP_STAGE_W-2:0],
				sync.level[SCP_I_SDATA]};
		end else if (par_active) begin
			if (sync.rise[SCP_I_UPPERWR]) begin
				counter_staging_register[SCP_F_UPPER +: 4] <= bus[3:0];
			end
			if (sync.rise[SCP_I_MAINWR]) begin
				counter_staging_register[SCP_F_MAIN_LO +: 8] <= bus;
			end
			if (sync.rise[SCP_I_SWALWR]) begin
				counter_staging_register[SCP_F_SWAL +: 8] <= bus;
			end
		end
	end

	// Shadow copy for frequency hopping
	always_ff @(posedge clk) begin
		if (reset) begin
			counter_shadow_copy <= SCP_WORD_RST;
		end else if (ser_active && (sync.rise[SCP_I_SLOAD] || sync.rise[SCP_I_HOP])) begin
			counter_shadow_copy <= counter_staging_register;
		end else if (par_active && sync.rise[SCP_I_HOP]) begin
			counter_shadow_copy <= counter_staging_register;
		end
	end

	// Serial option bits wait in a buffer so controls do not flicker mid-load
	always_ff @(posedge clk) begin
		if (reset) begin
			option_shift_buffer <= SCP_OPT_RST;
		end else if (shift_take && sync.level[SCP_I_OPT]) begin
			option_shift_buffer <= {option_shift_buffer[SCP_OPT_W-2:0],
				sync.level[SCP_I_SDATA]};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			option_control_register <= SCP_OPT_RST;
		end else if (ser_active && sync.fall[SCP_I_OPT]) begin
			option_control_register <= option_shift_buffer;
		end else if (par_active && sync.rise[SCP_I_OPT]) begin
			option_control_register <= bus;
		end
	end

	// Counter source selection
	always_comb begin
		selected = counter_shadow_copy;
		if (ser_active && sync.level[SCP_I_SSEL]) begin
			selected = counter_staging_register;
		end else if (par_active && sync.level[SCP_I_PSEL]) begin
			selected = counter_staging_register;
		end
		next_ref = {selected[SCP_F_REF_HI +: 2], selected[SCP_F_REF_LO +: 4]};
		next_main = {selected[SCP_F_MAIN_HI +: 2], selected[SCP_F_MAIN_LO +: 7]};
		next_swal = selected[SCP_F_SWAL +: 4];
		next_pre = selected[SCP_F_PRE];
		if (next_mode == SCP_MODE_DIR) begin
			// Swallow bits share pins with serial mode, the upper and option strobes and the parallel copy select
			next_ref = {2'h0, sync.level[SCP_I_REFPIN +: 4]};
			next_main = {2'h0, bus[6:0]};
			next_swal = {sync.level[SCP_I_SMODE], sync.level[SCP_I_UPPERWR],
				sync.level[SCP_I_OPT], sync.level[SCP_I_PSEL]};
			next_pre = bus[7];
		end
	end

	// Counters pick up a new source on the very next edge
	always_ff @(posedge clk) begin
		if (reset) begin
			ref_count <= 6'h00;
			main_count <= 9'h000;
			swallow_count <= 4'h0;
		end else begin
			ref_count <= next_ref;
			main_count <= next_main;
			swallow_count <= next_swal;
		end
	end

	// One means the input goes around the prescaler
	always_ff @(posedge clk) begin
		if (reset) begin
			prescaler_bypass <= 1'b0;
		end else begin
			prescaler_bypass <= next_pre;
		end
	end

	// Option bits gated by the enable pin; direct mode has no options
	always_comb begin
		next_opt_active = SCP_OPT_RST;
		if (!sync.level[SCP_I_ENH_N] && next_mode != SCP_MODE_DIR) begin
			next_opt_active = option_control_register;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			option_active <= SCP_OPT_RST;
		end else begin
			option_active <= next_opt_active;
		end
	end

	// Data out parks low unless its enable bit is set
	always_comb begin
		next_dout = 1'b0;
		if (next_opt_active[SCP_OPT_DOUT_EN]) begin
			if (next_opt_active[SCP_OPT_DOUT_RAW]) begin
				next_dout = sync.level[SCP_I_PRESC];
			end else begin
				next_dout = sync.level[SCP_I_MODSEL];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			data_out <= 1'b0;
		end else begin
			data_out <= next_dout;
		end
	end

	// A disabled monitor holds low rather than freezing mid-cycle
	assign next_main_mon = sync.level[SCP_I_MAINDIV]
		& ~next_opt_active[SCP_OPT_MAIN_MON_OFF];
	assign next_ref_mon = sync.level[SCP_I_REFDIV]
		& ~next_opt_active[SCP_OPT_REF_MON_OFF];

	always_ff @(posedge clk) begin
		if (reset) begin
			main_monitor <= 1'b0;
		end else begin
			main_monitor <= next_main_mon;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ref_monitor <= 1'b0;
		end else begin
			ref_monitor <= next_ref_mon;
		end
	end

	// Pump pulses leave the block active low, as the filter expects
	always_ff @(posedge clk) begin
		if (reset) begin
			pump_up_n <= 1'b1;
			pump_down_n <= 1'b1;
		end else begin
			pump_up_n <= ~pump_up;
			pump_down_n <= ~pump_down;
		end
	end

	// Either pump active means unlocked; resistor and filter cap are off-block
	assign next_pumping = ~(~pump_up & ~pump_down);

	always_ff @(posedge clk) begin
		if (reset) begin
			lock_filter <= 1'b0;
		end else begin
			lock_filter <= next_pumping;
		end
	end

	// Open drain: the pad only ever pulls low, so its data stays zero
	always_ff @(posedge clk) begin
		if (reset) begin
			lock_indicator_out <= 1'b0;
			lock_indicator_oe <= 1'b0;
		end else begin
			lock_indicator_out <= 1'b0;
			lock_indicator_oe <= next_pumping;
		end
	end

	// Both pumps idle leaves the loop filter floating
	always_ff @(posedge clk) begin
		if (reset) begin
			charge_pump_out <= 1'b0;
			charge_pump_oe <= 1'b0;
		end else begin
			charge_pump_out <= pump_up;
			charge_pump_oe <= pump_up ^ pump_down;
		end
	end
endmodule

/* File: verilog/scp_sync_if.sv */
// Purpose: Carries synchronised pin levels and their edges
// Assumes: One clock domain, the block clock
// Notes: Edges are single-cycle pulses
`timescale 1ns/1ns
interface scp_sync_if;
	import scp_pkg::*;
	logic [SCP_PINS-1:0] level;
	logic [SCP_PINS-1:0] rise;
	logic [SCP_PINS-1:0] fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface
